// >>> hw/sssi_pkg.sv
/*
 * Shared constants and types of the serial controller status/interrupt block:
 * register offsets, status bit positions, reset values and the state record.
 * Assumes a single 100 MHz clock domain and a simple strobe register port.
 */
package sssi_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int CNT_W  = 16;
   localparam int SYNC_W = 16;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFS_CONTROL        = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_TX_FRAME_MODE  = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_TX_HOLDING     = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_RX_HOLDING     = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_TX_SYNC_HOLD   = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_STATUS_FLAGS   = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_IRQ_EN_SET     = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_IRQ_EN_CLEAR   = 8'h1C;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK_VIEW  = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_TX_DMA_CNT     = 8'h24;
   localparam logic [ADDR_W-1:0] OFS_TX_DMA_NEXT    = 8'h28;
   localparam logic [ADDR_W-1:0] OFS_RX_DMA_CNT     = 8'h2C;
   localparam logic [ADDR_W-1:0] OFS_RX_DMA_NEXT    = 8'h30;

   // Control register command bits (write only, self clearing)
   localparam int CTL_TX_ON  = 0;
   localparam int CTL_TX_OFF = 1;
   localparam int CTL_RX_ON  = 2;
   localparam int CTL_RX_OFF = 3;

   // Frame mode field position
   localparam int TFM_EDGE_SEL = 24;

   // Status bit positions
   localparam int ST_TX_READY     = 0;
   localparam int ST_TX_DRAINED   = 1;
   localparam int ST_TX_CNT_DONE  = 2;
   localparam int ST_TX_BUF_EMPTY = 3;
   localparam int ST_RX_READY     = 4;
   localparam int ST_RX_OVERRUN   = 5;
   localparam int ST_RX_CNT_DONE  = 6;
   localparam int ST_RX_BUF_FULL  = 7;
   localparam int ST_TX_SYNC      = 10;
   localparam int ST_RX_SYNC      = 11;
   localparam int ST_TX_ON        = 16;
   localparam int ST_RX_ON        = 17;

   // Interrupt-capable status bits
   localparam logic [DATA_W-1:0] IRQ_BITS_MASK = 32'h0000_0CFF;

   localparam logic [CNT_W-1:0]  CNT_RESET  = 16'h0000;
   localparam logic [SYNC_W-1:0] SYNC_RESET = 16'h0000;
   localparam logic [DATA_W-1:0] WORD_RESET = 32'h0000_0000;

   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } sssi_bus_req_t;

   typedef struct packed {
      logic [DATA_W-1:0] rdata;
      logic [DATA_W-1:0] tx_word;
      logic [DATA_W-1:0] rx_word;
      logic [SYNC_W-1:0] tx_sync_bits;
      logic [CNT_W-1:0]  tx_cnt;
      logic [CNT_W-1:0]  tx_next_cnt;
      logic [CNT_W-1:0]  rx_cnt;
      logic [CNT_W-1:0]  rx_next_cnt;
      logic [DATA_W-1:0] irq_mask;
      logic              edge_sel;
      logic              tx_on;
      logic              rx_on;
      logic              tx_hold_full;
      logic              tx_shift_busy;
      logic              rx_hold_full;
      logic              tx_cnt_done;
      logic              rx_cnt_done;
      logic              rx_overrun;
      logic              tx_sync_seen;
      logic              rx_sync_seen;
      logic              fs_meta;
      logic              fs_sync;
      logic              fs_prev;
      logic              irq;
   } sssi_state_t;

endpackage : sssi_pkg

// >>> hw/sssi_top.sv
/*
 * Status flags, interrupt mask and transmit frame-sync holding register of a
 * synchronous serial controller, plus the transmit/receive holding handshake
 * and the peripheral DMA counters whose values drive the buffer flags.
 * Assumes: shifter, receiver and DMA engine run on CLK_IN and talk through
 * one-cycle pulses; the transmit frame-sync pin is asynchronous.
 */
// Implementation choices: the register addresses and the address-and-strobe port.
// Notes on behaviour
// - Frame-sync holding payload sits right-justified in bits 15..0; upper bits unused.
// - Status bit 0 is 1 when transmit holding is empty, 0 while word waits.
// - Status bit 1 is 1 when no word waits or shifts: after reset, or once the last written word was fully sent.
// - Bit 2 sets when transmit counter hits zero; counter writes clear it.
// - Bit 3 is 1 exactly when transmit counter and next-counter are zero.
// - Bit 4 is 1 while the receive holding register holds an unread word.
// - Bit 5 sets when a word overwrites an unread one; status read clears.
// - Bit 6 sets when receive counter hits zero; counter writes clear it.
// - Bit 7 is 1 exactly when receive counter and next-counter are zero.
// - Bit 10 sets on transmit frame sync, stays until status read.
// - Bit 11 sets on receive frame sync, stays until status read.
// - Bits 16 and 17 show transmitter and receiver enabled.
// - Writing 1 to enable-set turns that interrupt on; 0 changes nothing.
// - Writing 1 to enable-clear turns that interrupt off; 0 changes nothing.
// - Mask view reads 1 for each enabled interrupt, same bit layout.
// - Transmit sync flag uses rising edge when select is 0, falling when 1.
module sssi_top (
   input  wire logic                   CLK_IN,
   input  wire logic                   RESET_IN,
   input  wire sssi_pkg::sssi_bus_req_t BUS_REQ_IN,
   output logic [sssi_pkg::DATA_W-1:0] BUS_RDATA_OUT,
   output logic [sssi_pkg::DATA_W-1:0] TX_WORD_OUT,
   output logic                        TX_WORD_VALID_OUT,
   input  wire logic                   TX_LOAD_IN,
   input  wire logic                   TX_SHIFT_DONE_IN,
   output logic [sssi_pkg::SYNC_W-1:0] TX_SYNC_BITS_OUT,
   input  wire logic                   TX_FSYNC_PIN_IN,
   input  wire logic                   RX_LOAD_IN,
   input  wire logic [sssi_pkg::DATA_W-1:0] RX_WORD_IN,
   input  wire logic                   RX_SYNC_EVENT_IN,
   input  wire logic                   TX_DMA_XFER_IN,
   input  wire logic                   RX_DMA_XFER_IN,
   output logic                        TX_ENABLE_OUT,
   output logic                        RX_ENABLE_OUT,
   output logic                        IRQ_OUT
);
   import sssi_pkg::*;

   sssi_state_t       state;
   sssi_state_t       next_state;
   logic [DATA_W-1:0] status_word;
   logic [DATA_W-1:0] next_status_word;
   logic              wr_hit;
   logic              rd_hit;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic              fs_event;
   logic              status_read;
   logic              tx_cnt_write;
   logic              rx_cnt_write;
   logic              tx_take;
   logic              tx_cnt_hits_zero;
   logic              rx_cnt_hits_zero;

   // Packs a state record into the status layout
   function automatic logic [DATA_W-1:0] pack_status(input sssi_state_t s);
      logic [DATA_W-1:0] w;
      w                  = WORD_RESET;
      w[ST_TX_READY]     = ~s.tx_hold_full;
      w[ST_TX_DRAINED]   = ~s.tx_hold_full & ~s.tx_shift_busy;
      w[ST_TX_CNT_DONE]  = s.tx_cnt_done;
      w[ST_TX_BUF_EMPTY] = (s.tx_cnt == CNT_RESET)
                           && (s.tx_next_cnt == CNT_RESET);
      w[ST_RX_READY]     = s.rx_hold_full;
      w[ST_RX_OVERRUN]   = s.rx_overrun;
      w[ST_RX_CNT_DONE]  = s.rx_cnt_done;
      w[ST_RX_BUF_FULL]  = (s.rx_cnt == CNT_RESET)
                           && (s.rx_next_cnt == CNT_RESET);
      w[ST_TX_SYNC]      = s.tx_sync_seen;
      w[ST_RX_SYNC]      = s.rx_sync_seen;
      w[ST_TX_ON]        = s.tx_on;
      w[ST_RX_ON]        = s.rx_on;
      return w;
   endfunction

   assign addr  = BUS_REQ_IN.addr;
   assign wdata = BUS_REQ_IN.wdata;
   assign wr_hit = BUS_REQ_IN.wr;
   assign rd_hit = BUS_REQ_IN.rd;

   assign status_word = pack_status(state);

   // Edge of the synchronised pin; meta stage feeds only fs_sync
   assign fs_event = state.edge_sel ? (state.fs_prev & ~state.fs_sync)
                                    : (~state.fs_prev & state.fs_sync);

   assign status_read  = rd_hit && (addr == OFS_STATUS_FLAGS);
   assign tx_cnt_write = wr_hit && ((addr == OFS_TX_DMA_CNT) || (addr == OFS_TX_DMA_NEXT));
   assign rx_cnt_write = wr_hit && ((addr == OFS_RX_DMA_CNT) || (addr == OFS_RX_DMA_NEXT));

   // Shifter only takes a word that is actually waiting
   assign tx_take = TX_LOAD_IN && state.tx_hold_full;

   // A transfer pulse on a zero counter is ignored
   assign tx_cnt_hits_zero = TX_DMA_XFER_IN && (state.tx_cnt == {{(CNT_W-1){1'b0}}, 1'b1});
   assign rx_cnt_hits_zero = RX_DMA_XFER_IN && (state.rx_cnt == {{(CNT_W-1){1'b0}}, 1'b1});

   always_comb begin
      next_state = state;
      next_state.rdata = WORD_RESET;

      // Two-flop synchroniser plus edge history
      next_state.fs_meta = TX_FSYNC_PIN_IN;
      next_state.fs_sync = state.fs_meta;
      next_state.fs_prev = state.fs_sync;

      // Control commands; disable wins if both set
      if (wr_hit && (addr == OFS_CONTROL)) begin
         if (wdata[CTL_TX_ON]) begin
            next_state.tx_on = 1'b1;
         end
         if (wdata[CTL_TX_OFF]) begin
            next_state.tx_on = 1'b0;
         end
         if (wdata[CTL_RX_ON]) begin
            next_state.rx_on = 1'b1;
         end
         if (wdata[CTL_RX_OFF]) begin
            next_state.rx_on = 1'b0;
         end
      end

      if (wr_hit && (addr == OFS_TX_FRAME_MODE)) begin
         next_state.edge_sel = wdata[TFM_EDGE_SEL];
      end

      if (wr_hit && (addr == OFS_TX_SYNC_HOLD)) begin
         next_state.tx_sync_bits = wdata[SYNC_W-1:0];
      end

      // Transmit holding and shifter occupancy
      if (tx_take) begin
         next_state.tx_hold_full  = 1'b0;
         next_state.tx_shift_busy = 1'b1;
      end else if (TX_SHIFT_DONE_IN) begin
         next_state.tx_shift_busy = 1'b0;
      end
      // A write in the load cycle refills the holding register
      if (wr_hit && (addr == OFS_TX_HOLDING)) begin
         next_state.tx_word      = wdata;
         next_state.tx_hold_full = 1'b1;
      end

      // Receive holding; reading it empties it, new load wins
      if (rd_hit && (addr == OFS_RX_HOLDING)) begin
         next_state.rx_hold_full = 1'b0;
      end

      // Read-to-clear flags; set below overrides clear
      if (status_read) begin
         next_state.rx_overrun   = 1'b0;
         next_state.tx_sync_seen = 1'b0;
         next_state.rx_sync_seen = 1'b0;
      end

      if (RX_LOAD_IN) begin
         next_state.rx_word      = RX_WORD_IN;
         next_state.rx_hold_full = 1'b1;
         if (state.rx_hold_full && !(rd_hit && (addr == OFS_RX_HOLDING))) begin
            next_state.rx_overrun = 1'b1;
         end
      end

      if (fs_event) begin
         next_state.tx_sync_seen = 1'b1;
      end
      if (RX_SYNC_EVENT_IN) begin
         next_state.rx_sync_seen = 1'b1;
      end

      // Transmit DMA counters: reload from next when count runs out
      if (TX_DMA_XFER_IN && (state.tx_cnt != CNT_RESET)) begin
         next_state.tx_cnt = state.tx_cnt - {{(CNT_W-1){1'b0}}, 1'b1};
         if (tx_cnt_hits_zero && (state.tx_next_cnt != CNT_RESET)) begin
            next_state.tx_cnt      = state.tx_next_cnt;
            next_state.tx_next_cnt = CNT_RESET;
         end
      end
      if (tx_cnt_write) begin
         next_state.tx_cnt_done = 1'b0;
      end
      if (wr_hit && (addr == OFS_TX_DMA_CNT)) begin
         next_state.tx_cnt = wdata[CNT_W-1:0];
      end
      if (wr_hit && (addr == OFS_TX_DMA_NEXT)) begin
         next_state.tx_next_cnt = wdata[CNT_W-1:0];
      end
      if (tx_cnt_hits_zero) begin
         next_state.tx_cnt_done = 1'b1;
      end

      // Receive DMA counters, same scheme
      if (RX_DMA_XFER_IN && (state.rx_cnt != CNT_RESET)) begin
         next_state.rx_cnt = state.rx_cnt - {{(CNT_W-1){1'b0}}, 1'b1};
         if (rx_cnt_hits_zero && (state.rx_next_cnt != CNT_RESET)) begin
            next_state.rx_cnt      = state.rx_next_cnt;
            next_state.rx_next_cnt = CNT_RESET;
         end
      end
      if (rx_cnt_write) begin
         next_state.rx_cnt_done = 1'b0;
      end
      if (wr_hit && (addr == OFS_RX_DMA_CNT)) begin
         next_state.rx_cnt = wdata[CNT_W-1:0];
      end
      if (wr_hit && (addr == OFS_RX_DMA_NEXT)) begin
         next_state.rx_next_cnt = wdata[CNT_W-1:0];
      end
      if (rx_cnt_hits_zero) begin
         next_state.rx_cnt_done = 1'b1;
      end

      // Interrupt enables; clear applied after set
      if (wr_hit && (addr == OFS_IRQ_EN_SET)) begin
         next_state.irq_mask = state.irq_mask | (wdata & IRQ_BITS_MASK);
      end
      if (wr_hit && (addr == OFS_IRQ_EN_CLEAR)) begin
         next_state.irq_mask = state.irq_mask & ~(wdata & IRQ_BITS_MASK);
      end

      // Read data, answered the cycle after the strobe
      if (rd_hit) begin
         if (addr == OFS_CONTROL) begin
            next_state.rdata = WORD_RESET;
         end else if (addr == OFS_TX_FRAME_MODE) begin
            next_state.rdata = WORD_RESET;
            next_state.rdata[TFM_EDGE_SEL] = state.edge_sel;
         end else if (addr == OFS_RX_HOLDING) begin
            next_state.rdata = state.rx_word;
         end else if (addr == OFS_TX_SYNC_HOLD) begin
            next_state.rdata = {{(DATA_W-SYNC_W){1'b0}}, state.tx_sync_bits};
         end else if (addr == OFS_STATUS_FLAGS) begin
            next_state.rdata = status_word;
         end else if (addr == OFS_IRQ_MASK_VIEW) begin
            next_state.rdata = state.irq_mask;
         end else if (addr == OFS_TX_DMA_CNT) begin
            next_state.rdata = {{(DATA_W-CNT_W){1'b0}}, state.tx_cnt};
         end else if (addr == OFS_TX_DMA_NEXT) begin
            next_state.rdata = {{(DATA_W-CNT_W){1'b0}}, state.tx_next_cnt};
         end else if (addr == OFS_RX_DMA_CNT) begin
            next_state.rdata = {{(DATA_W-CNT_W){1'b0}}, state.rx_cnt};
         end else if (addr == OFS_RX_DMA_NEXT) begin
            next_state.rdata = {{(DATA_W-CNT_W){1'b0}}, state.rx_next_cnt};
         end else begin
            // Write-only and unmapped addresses read as zero
            next_state.rdata = WORD_RESET;
         end
      end

      // Registered from the next state so the pin tracks the flags exactly
      next_status_word = pack_status(next_state);
      next_state.irq   = |(next_status_word & next_state.irq_mask & IRQ_BITS_MASK);
   end

   always_ff @(posedge CLK_IN) begin
      if (RESET_IN) begin
         state              <= '0;
         state.tx_word      <= WORD_RESET;
         state.rx_word      <= WORD_RESET;
         state.tx_sync_bits <= SYNC_RESET;
         state.tx_cnt       <= CNT_RESET;
         state.tx_next_cnt  <= CNT_RESET;
         state.rx_cnt       <= CNT_RESET;
         state.rx_next_cnt  <= CNT_RESET;
         state.irq_mask     <= WORD_RESET;
      end else begin
         state <= next_state;
      end
   end

   assign BUS_RDATA_OUT     = state.rdata;
   assign TX_WORD_OUT       = state.tx_word;
   assign TX_WORD_VALID_OUT = state.tx_hold_full;
   assign TX_SYNC_BITS_OUT  = state.tx_sync_bits;
   assign TX_ENABLE_OUT     = state.tx_on;
   assign RX_ENABLE_OUT     = state.rx_on;
   assign IRQ_OUT           = state.irq;

endmodule // sssi_top

// >>> verif/sssi_properties.sv
/* Checker for sssi_top: bus read data, holding handshake, enables, irq.
   Assumes it is bound onto sssi_top and sees its ports only. */
module sssi_properties (
   input wire logic                    CLK_IN,
   input wire logic                    RESET_IN,
   input wire sssi_pkg::sssi_bus_req_t BUS_REQ_IN,
   input wire logic [31:0]             BUS_RDATA_OUT,
   input wire logic [31:0]             TX_WORD_OUT,
   input wire logic                    TX_WORD_VALID_OUT,
   input wire logic                    TX_LOAD_IN,
   input wire logic [15:0]             TX_SYNC_BITS_OUT,
   input wire logic                    TX_ENABLE_OUT,
   input wire logic                    RX_ENABLE_OUT,
   input wire logic                    IRQ_OUT
);
   timeunit 1ns;
   timeprecision 1ps;
   import sssi_pkg::*;
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (RESET_IN);
   sequence s_wr(logic [7:0] a);
      BUS_REQ_IN.wr && BUS_REQ_IN.addr == a;
   endsequence
   sequence s_cmd(int b);
      BUS_REQ_IN.wr && BUS_REQ_IN.addr == OFS_CONTROL && BUS_REQ_IN.wdata[b];
   endsequence
   a_rdata_quiet: assert property (!$past(BUS_REQ_IN.rd) |-> BUS_RDATA_OUT == 32'h0000_0000)
      else $error("read data not zero outside read slot");
   a_sync_payload: assert property (s_wr(OFS_TX_SYNC_HOLD) |=>
      TX_SYNC_BITS_OUT == $past(BUS_REQ_IN.wdata[15:0])) else $error("sync payload wrong");
   a_word_waits: assert property (s_wr(OFS_TX_HOLDING) |=>
      TX_WORD_VALID_OUT && TX_WORD_OUT == $past(BUS_REQ_IN.wdata)) else $error("word not held");
   a_word_taken: assert property (TX_WORD_VALID_OUT && TX_LOAD_IN && !BUS_REQ_IN.wr
      |=> !TX_WORD_VALID_OUT) else $error("holding not emptied by load");
   a_word_stays: assert property (TX_WORD_VALID_OUT && !TX_LOAD_IN |=> TX_WORD_VALID_OUT)
      else $error("waiting word lost");
   a_tx_switch_on: assert property (s_cmd(CTL_TX_ON) ##0 !BUS_REQ_IN.wdata[CTL_TX_OFF]
      |=> TX_ENABLE_OUT) else $error("transmitter not enabled");
   a_tx_switch_off: assert property (s_cmd(CTL_TX_OFF) |=> !TX_ENABLE_OUT)
      else $error("transmitter not disabled");
   a_rx_switch_on: assert property (s_cmd(CTL_RX_ON) ##0 !BUS_REQ_IN.wdata[CTL_RX_OFF]
      |=> RX_ENABLE_OUT) else $error("receiver not enabled");
   a_rx_switch_off: assert property (s_cmd(CTL_RX_OFF) |=> !RX_ENABLE_OUT)
      else $error("receiver not disabled");
   a_irq_all_off: assert property (s_wr(OFS_IRQ_EN_CLEAR) ##0
      BUS_REQ_IN.wdata[11:0] == 12'hCFF ##1
      !(BUS_REQ_IN.wr && BUS_REQ_IN.addr == OFS_IRQ_EN_SET) |=> !IRQ_OUT)
      else $error("interrupt high with all sources disabled");
endmodule // sssi_properties

bind sssi_top sssi_properties u_props (.CLK_IN(CLK_IN), .RESET_IN(RESET_IN),
   .BUS_REQ_IN(BUS_REQ_IN), .BUS_RDATA_OUT(BUS_RDATA_OUT), .TX_WORD_OUT(TX_WORD_OUT),
   .TX_WORD_VALID_OUT(TX_WORD_VALID_OUT), .TX_LOAD_IN(TX_LOAD_IN),
   .TX_SYNC_BITS_OUT(TX_SYNC_BITS_OUT), .TX_ENABLE_OUT(TX_ENABLE_OUT),
   .RX_ENABLE_OUT(RX_ENABLE_OUT), .IRQ_OUT(IRQ_OUT));

// >>> verif/sssi_shifter_model.sv
/* Far-side shifter: takes the waiting word, later reports it sent.
   Assumes the holding handshake of sssi_top; delay_in sets its speed. */
module sssi_shifter_model (
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic        valid_in,
   input  wire logic [31:0] word_in,
   input  wire logic [2:0]  delay_in,
   output logic             load_out,
   output logic             done_out,
   output logic [31:0]      word_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] phase;
   logic [2:0] cnt;
   always @(posedge clk_in) begin
      load_out <= 1'h0;
      done_out <= 1'h0;
      if (rst_in) begin
         phase <= 2'h0;
         cnt   <= 3'h0;
      end else if (phase == 2'h1) begin
         // Valid drops one edge after load; skip it to avoid a second take
         phase <= 2'h2;
      end else if (cnt != delay_in && (phase == 2'h2 || valid_in)) begin
         cnt <= cnt + 3'h1;
      end else if (phase == 2'h2) begin
         done_out <= 1'h1;
         phase    <= 2'h0;
         cnt      <= 3'h0;
      end else if (valid_in) begin
         load_out <= 1'h1;
         word_out <= word_in;
         phase    <= 2'h1;
         cnt      <= 3'h0;
      end
   end
endmodule // sssi_shifter_model

// >>> verif/testbench.sv
/* Self-checking bench for sssi_top with shifter model and bound checker.
   Assumes the register map of sssi_pkg and a strobe register port. */
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
   $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import sssi_pkg::*;
   logic          clk, rst, tx_load, tx_done, fsync, rx_load, rx_sync, tx_xfer, rx_xfer;
   logic          tx_valid, tx_en, rx_en, irq;
   logic [31:0]   rdata, tx_word, rx_word, seen, lfsr, w, m, b;
   logic [15:0]   sync_bits;
   logic [2:0]    dly;
   sssi_bus_req_t bus;
   int            n_errors, n_compared;
   localparam logic [31:0] ALL = 32'hFFFF_FFFF;

   sssi_top DUT (.CLK_IN(clk), .RESET_IN(rst), .BUS_REQ_IN(bus), .BUS_RDATA_OUT(rdata),
      .TX_WORD_OUT(tx_word), .TX_WORD_VALID_OUT(tx_valid), .TX_LOAD_IN(tx_load),
      .TX_SHIFT_DONE_IN(tx_done), .TX_SYNC_BITS_OUT(sync_bits), .TX_FSYNC_PIN_IN(fsync),
      .RX_LOAD_IN(rx_load), .RX_WORD_IN(rx_word), .RX_SYNC_EVENT_IN(rx_sync),
      .TX_DMA_XFER_IN(tx_xfer), .RX_DMA_XFER_IN(rx_xfer), .TX_ENABLE_OUT(tx_en),
      .RX_ENABLE_OUT(rx_en), .IRQ_OUT(irq));
   sssi_shifter_model u_shift (.clk_in(clk), .rst_in(rst), .valid_in(tx_valid),
      .word_in(tx_word), .delay_in(dly), .load_out(tx_load), .done_out(tx_done),
      .word_out(seen));

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [31:0] bit_at(input int p);
      return 32'h0000_0001 << p;
   endfunction
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic put(input logic [7:0] a, input logic [31:0] d);
      bus <= '{1'h1, 1'h0, a, d};
      @(posedge clk);
      bus <= '0;
      @(posedge clk);
   endtask
   task automatic get(input logic [7:0] a, output logic [31:0] d);
      bus <= '{1'h0, 1'h1, a, 32'h0000_0000};
      @(posedge clk);
      bus <= '0;
      #1 d = rdata;
      @(posedge clk);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] k);
      logic [31:0] d;
      get(a, d);
      `CHK($sformatf("reg %h", a), e & k, d & k)
   endtask
   task automatic tally_and_finish;
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end
   initial begin
      tick(5000);
      n_errors++;
      tally_and_finish;
   end

   initial begin
      {rst, tx_xfer, rx_xfer, fsync, rx_load, rx_sync} = 6'h20;
      {bus, rx_word, dly, n_errors, n_compared} = '0;
      lfsr = 32'h0000_0043;
      tick(3);
      rst <= 1'h0;
      @(posedge clk);
      rchk(OFS_STATUS_FLAGS, 32'h0000_008B, ALL);
      rchk(OFS_IRQ_MASK_VIEW, 32'h0000_0000, ALL);
      rchk(8'hFC, 32'h0000_0000, ALL);
      put(OFS_CONTROL, 32'h0000_0005);
      rchk(OFS_STATUS_FLAGS, 32'h0003_0000, 32'h0003_0000);
      `CHK("tx_en", 1'h1, tx_en)
      `CHK("rx_en", 1'h1, rx_en)
      put(OFS_CONTROL, 32'h0000_000A);
      rchk(OFS_STATUS_FLAGS, 32'h0000_0000, 32'h0003_0000);
      `CHK("tx_en", 1'h0, tx_en)
      `CHK("rx_en", 1'h0, rx_en)
      // Off wins when both commands arrive together
      put(OFS_CONTROL, 32'h0000_0003);
      rchk(OFS_STATUS_FLAGS, 32'h0000_0000, 32'h0001_0000);
      put(OFS_CONTROL, 32'h0000_0005);
      lfsr = lfsr_next(lfsr);
      put(OFS_TX_SYNC_HOLD, lfsr);
      rchk(OFS_TX_SYNC_HOLD, lfsr & 32'h0000_FFFF, ALL);
      `CHK("sync_bits", lfsr[15:0], sync_bits)
      for (int i = 0; i < 4; i++) begin
         lfsr = lfsr_next(lfsr);
         dly <= (i == 0) ? 3'h7 : lfsr[2:0];
         put(OFS_TX_HOLDING, lfsr);
         if (i == 0) rchk(OFS_STATUS_FLAGS, 32'h0000_0000, 32'h0000_0003);
         for (int t = 0; t < 64 && tx_done !== 1'h1; t++) @(posedge clk);
         `CHK("tx_word", lfsr, seen)
         rchk(OFS_STATUS_FLAGS, 32'h0000_0003, 32'h0000_0003);
      end
      put(OFS_IRQ_EN_SET, 32'h0000_0001);
      put(OFS_IRQ_EN_SET, 32'h0000_0000);
      rchk(OFS_IRQ_MASK_VIEW, 32'h0000_0001, ALL);
      #1 `CHK("irq", 1'h1, irq)
      put(OFS_IRQ_EN_SET, ALL);
      rchk(OFS_IRQ_MASK_VIEW, 32'h0000_0CFF, ALL);
      put(OFS_IRQ_EN_CLEAR, 32'h0000_0C00);
      rchk(OFS_IRQ_MASK_VIEW, 32'h0000_00FF, ALL);
      put(OFS_IRQ_EN_CLEAR, 32'h0000_0CFF);
      #1 `CHK("irq", 1'h0, irq)
      put(OFS_IRQ_EN_SET, bit_at(ST_RX_OVERRUN));
      for (int i = 0; i < 2; i++) begin
         lfsr = lfsr_next(lfsr);
         rx_word <= lfsr;
         rx_load <= 1'h1;
         @(posedge clk);
         rx_load <= 1'h0;
         @(posedge clk);
      end
      #1 `CHK("irq", 1'h1, irq)
      rchk(OFS_STATUS_FLAGS, 32'h0000_0030, 32'h0000_0030);
      rchk(OFS_STATUS_FLAGS, 32'h0000_0010, 32'h0000_0030);
      #1 `CHK("irq", 1'h0, irq)
      rchk(OFS_RX_HOLDING, lfsr, ALL);
      rchk(OFS_STATUS_FLAGS, 32'h0000_0000, 32'h0000_0010);
      for (int k = 0; k < 2; k++) begin
         b = bit_at(k ? ST_RX_BUF_FULL : ST_TX_BUF_EMPTY);
         m = b | bit_at(k ? ST_RX_CNT_DONE : ST_TX_CNT_DONE);
         put(k ? OFS_RX_DMA_CNT : OFS_TX_DMA_CNT, 32'h0000_0002);
         rchk(OFS_STATUS_FLAGS, 32'h0000_0000, m);
         repeat (2) begin
            tx_xfer <= (k == 0);
            rx_xfer <= (k == 1);
            @(posedge clk);
            tx_xfer <= 1'h0;
            rx_xfer <= 1'h0;
            @(posedge clk);
         end
         rchk(OFS_STATUS_FLAGS, m, m);
         put(k ? OFS_RX_DMA_NEXT : OFS_TX_DMA_NEXT, 32'h0000_0003);
         rchk(OFS_STATUS_FLAGS, 32'h0000_0000, m);
         put(k ? OFS_RX_DMA_NEXT : OFS_TX_DMA_NEXT, 32'h0000_0000);
         rchk(OFS_STATUS_FLAGS, b, m);
      end
      for (int e = 0; e < 2; e++) begin
         put(OFS_TX_FRAME_MODE, bit_at(TFM_EDGE_SEL) & {32{e[0]}});
         fsync <= e[0];
         tick(6);
         get(OFS_STATUS_FLAGS, w);
         // The unselected edge (or none) came before, so no flag yet
         `CHK("tx_sync", 1'h0, w[ST_TX_SYNC])
         fsync <= !e[0];
         tick(6);
         rchk(OFS_STATUS_FLAGS, bit_at(ST_TX_SYNC), bit_at(ST_TX_SYNC));
         // Opposite edge must not set the flag again
         fsync <= e[0];
         tick(6);
         rchk(OFS_STATUS_FLAGS, 32'h0000_0000, bit_at(ST_TX_SYNC));
      end
      rx_sync <= 1'h1;
      @(posedge clk);
      rx_sync <= 1'h0;
      tick(2);
      rchk(OFS_STATUS_FLAGS, bit_at(ST_RX_SYNC), bit_at(ST_RX_SYNC));
      rchk(OFS_STATUS_FLAGS, 32'h0000_0000, bit_at(ST_RX_SYNC));
      tally_and_finish;
   end
endmodule // testbench
